/* File: pkg/ccp_cache_map.vh */
`ifndef CCP_CACHE_MAP_VH
`define CCP_CACHE_MAP_VH
// =========================================
// register space select
`define CCP_SPACE_CTRL 2'h0
`define CCP_SPACE_INFO 2'h1
`define CCP_SPACE_DATA 2'h2
// =========================================
// control register offsets
`define CCP_OFF_PROF_BASE 12'h400
`define CCP_OFF_PROF_STRIDE 12'h020
`define CCP_OFF_INSTR_HIT 12'h400
`define CCP_OFF_INSTR_MISS 12'h404
`define CCP_OFF_LOAD_HIT 12'h408
`define CCP_OFF_LOAD_MISS 12'h40C
`define CCP_OFF_ENABLE 12'h500
`define CCP_OFF_INVALIDATE 12'h504
`define CCP_OFF_ERASE 12'h508
`define CCP_OFF_CNT_ENABLE 12'h50C
`define CCP_OFF_CNT_CLEAR 12'h510
`define CCP_OFF_MODE 12'h514
`define CCP_OFF_INSP_LOCK 12'h518
`define CCP_OFF_ERASE_PROG 12'h51C
`define CCP_OFF_REFILL_LOCK 12'h520
// =========================================
// window layout
`define CCP_INFO_SET_STRIDE 13'h008
`define CCP_INFO_WAY_STRIDE 13'h004
`define CCP_DATA_WAY_STRIDE 13'h010
`define CCP_DATA_WORD_STRIDE 13'h004
// =========================================
// field positions
`define CCP_BIT_CTRL 0
`define CCP_BIT_VALID 30
`define CCP_BIT_RECENT 31
// =========================================
// reset values
`define CCP_RST_ZERO 32'h00000000
// mode bit: 0 cache operation, 1 ram operation
`define CCP_MODE_RAM 1'b1
// =========================================
// erase walk length, one line per cycle
`define CCP_ERASE_CYCLES 10'h200
`endif

/* File: hdl/ccp_cache_ctrl.v */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "ccp_cache_map.vh"

module ccp_cache_ctrl #(
	parameter TAG_W = 20,
	parameter SETS = 256
)(
	input wire mclk, // 125 MHz clock
	input wire rst_n, // synchronous reset, active low
	input wire [1:0] sw_space, // 0 control, 1 info window, 2 data window
	input wire [12:0] sw_addr, // byte address within space
	input wire [31:0] sw_wdata, // write data
	input wire sw_wr, // write strobe
	input wire sw_rd, // read strobe
	output reg [31:0] sw_rdata_ff, // read data, cycle after strobe
	input wire fetch_req, // lookup request
	input wire [31:0] fetch_addr, // fetch byte address
	input wire fetch_instr, // 1 instruction, 0 load
	input wire fetch_region, // 0 flash, 1 execute_in_place_region
	output reg fetch_done_ff, // answer pulse
	output reg fetch_hit_ff, // answer served from cache
	output reg [31:0] fetch_rdata_ff, // hit word
	input wire refill_valid, // line from flash side
	input wire [31:0] refill_addr, // line address
	input wire [127:0] refill_data, // line content
	output wire refill_ready // line will be allocated
);

// =========================================
// storage
reg [127:0] data_mem [0:2*SETS-1];
reg [TAG_W-1:0] tag_mem [0:2*SETS-1];
reg [2*SETS-1:0] valid_ff;
reg [SETS-1:0] recent_ff;

// =========================================
// control registers
reg enable_ff;
reg cnt_en_ff;
reg mode_ff;
reg insp_lock_ff;
reg refill_lock_ff;
reg erase_busy_ff;
reg [8:0] erase_idx_ff;
reg [31:0] cnt_ff [0:7];

wire ctrl_wr = sw_wr && sw_space == `CCP_SPACE_CTRL;
wire [11:0] coff = sw_addr[11:0];
wire ram_mode = mode_ff == `CCP_MODE_RAM;
wire caching = enable_ff && !ram_mode && !erase_busy_ff;
wire lock_eff = insp_lock_ff && !ram_mode;
wire refill_lock_eff = refill_lock_ff && !ram_mode;

wire wr_enable = ctrl_wr && coff == `CCP_OFF_ENABLE;
wire wr_inval = ctrl_wr && coff == `CCP_OFF_INVALIDATE && sw_wdata[`CCP_BIT_CTRL];
wire wr_erase = ctrl_wr && coff == `CCP_OFF_ERASE && sw_wdata[`CCP_BIT_CTRL];
wire wr_mode = ctrl_wr && coff == `CCP_OFF_MODE;
wire wr_cnt_clr = ctrl_wr && coff == `CCP_OFF_CNT_CLEAR;
wire to_ram = wr_mode && sw_wdata[`CCP_BIT_CTRL] == `CCP_MODE_RAM && !ram_mode;
wire to_cache = wr_mode && sw_wdata[`CCP_BIT_CTRL] != `CCP_MODE_RAM && ram_mode;
wire disable_now = wr_enable && !sw_wdata[`CCP_BIT_CTRL] && enable_ff;
wire erase_start = (wr_erase || to_ram) && !erase_busy_ff;
// all valid bits drop together; no per-line walk needed
wire clear_valid = wr_inval || disable_now || to_cache || erase_start;

// =========================================
// fetch lookup
wire [7:0] f_set = fetch_addr[11:4];
wire [TAG_W-1:0] f_tag = fetch_addr[TAG_W+11:12];
wire hit0 = valid_ff[{f_set, 1'b0}] && tag_mem[{f_set, 1'b0}] == f_tag;
wire hit1 = valid_ff[{f_set, 1'b1}] && tag_mem[{f_set, 1'b1}] == f_tag;
wire f_lookup = fetch_req && caching;
wire f_hit = f_lookup && (hit0 || hit1);
wire f_way = hit1;
wire [127:0] f_line = data_mem[{f_set, f_way}];

// =========================================
// refill allocation
wire [7:0] r_set = refill_addr[11:4];
wire r_v0 = valid_ff[{r_set, 1'b0}];
wire r_v1 = valid_ff[{r_set, 1'b1}];
// invalid way first, else the one not used most recently
wire r_way = !r_v0 ? 1'b0 : (!r_v1 ? 1'b1 : !recent_ff[r_set]);
assign refill_ready = caching && !refill_lock_eff && !clear_valid;
wire r_take = refill_valid && refill_ready;

// =========================================
// software window access
wire [8:0] info_idx = sw_addr[11:3];
wire info_way = sw_addr[2];
wire [8:0] data_idx = sw_addr[12:4];
wire [1:0] data_word = sw_addr[3:2];
wire [127:0] sw_line = data_mem[data_idx];
wire data_wr = sw_wr && sw_space == `CCP_SPACE_DATA && ram_mode && !erase_busy_ff;

// =========================================
// line storage, no reset on arrays
always @(posedge mclk)
begin
	if (erase_busy_ff)
		data_mem[erase_idx_ff] <= 128'h0;
	else if (data_wr)
		data_mem[data_idx][data_word*32 +: 32] <= sw_wdata;
	else if (r_take)
		data_mem[{r_set, r_way}] <= refill_data;
	if (r_take)
		tag_mem[{r_set, r_way}] <= refill_addr[TAG_W+11:12];
end

// =========================================
// valid and recent bits
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		valid_ff <= {2*SETS{1'b0}};
		recent_ff <= {SETS{1'b0}};
	end
	else
	begin
		// invalidation beats a refill landing in the same cycle
		if (clear_valid)
			valid_ff <= {2*SETS{1'b0}};
		else if (r_take)
			valid_ff[{r_set, r_way}] <= 1'b1;
		if (r_take)
			recent_ff[r_set] <= r_way;
		else if (f_hit)
			recent_ff[f_set] <= f_way;
	end
end

// =========================================
// control state
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		enable_ff <= 1'b0;
		cnt_en_ff <= 1'b0;
		mode_ff <= 1'b0;
		insp_lock_ff <= 1'b0;
		refill_lock_ff <= 1'b0;
		erase_busy_ff <= 1'b0;
		erase_idx_ff <= 9'h000;
	end
	else
	begin
		if (wr_enable)
			enable_ff <= sw_wdata[`CCP_BIT_CTRL];
		if (ctrl_wr && coff == `CCP_OFF_CNT_ENABLE)
			cnt_en_ff <= sw_wdata[`CCP_BIT_CTRL];
		if (wr_mode)
			mode_ff <= sw_wdata[`CCP_BIT_CTRL];
		// only a reset brings the lock back down
		if (ctrl_wr && coff == `CCP_OFF_INSP_LOCK && sw_wdata[`CCP_BIT_CTRL])
			insp_lock_ff <= 1'b1;
		if (ctrl_wr && coff == `CCP_OFF_REFILL_LOCK)
			refill_lock_ff <= sw_wdata[`CCP_BIT_CTRL];
		if (erase_start)
		begin
			erase_busy_ff <= 1'b1;
			erase_idx_ff <= 9'h000;
		end
		else if (erase_busy_ff)
		begin
			erase_idx_ff <= erase_idx_ff + 9'h001;
			if ({1'b0, erase_idx_ff} == `CCP_ERASE_CYCLES - 10'h001)
				erase_busy_ff <= 1'b0;
		end
	end
end

// =========================================
// profiling counters: index {region, load, miss}
genvar g;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : g_cnt
		localparam [2:0] KIND = g;
		wire kind_ok = {fetch_region, !fetch_instr, !f_hit} == KIND;
		always @(posedge mclk)
		begin
			if (!rst_n)
				cnt_ff[g] <= `CCP_RST_ZERO;
			else if (wr_cnt_clr)
				cnt_ff[g] <= `CCP_RST_ZERO;
			else if (cnt_en_ff && f_lookup && kind_ok)
				cnt_ff[g] <= cnt_ff[g] + 32'h00000001;
		end
	end
endgenerate

// =========================================
// fetch answer
always @(posedge mclk)
begin
	if (!rst_n)
	begin
		fetch_done_ff <= 1'b0;
		fetch_hit_ff <= 1'b0;
		fetch_rdata_ff <= `CCP_RST_ZERO;
	end
	else
	begin
		fetch_done_ff <= fetch_req;
		fetch_hit_ff <= f_hit;
		if (f_hit)
			fetch_rdata_ff <= f_line[fetch_addr[3:2]*32 +: 32];
	end
end

// =========================================
// read mux
wire [11:0] prof_rel = coff - `CCP_OFF_PROF_BASE;
wire prof_hit = coff >= `CCP_OFF_PROF_BASE && prof_rel < 2 * `CCP_OFF_PROF_STRIDE
	&& prof_rel[4] == 1'b0 && prof_rel[1:0] == 2'h0;
reg [31:0] nxt_rdata;

always @*
begin
	nxt_rdata = `CCP_RST_ZERO;
	case (sw_space)
		`CCP_SPACE_CTRL:
		begin
			if (prof_hit)
				nxt_rdata = cnt_ff[{prof_rel[5], prof_rel[3:2]}];
			else if (coff == `CCP_OFF_ENABLE)
				nxt_rdata = {31'h0, enable_ff};
			else if (coff == `CCP_OFF_CNT_ENABLE)
				nxt_rdata = {31'h0, cnt_en_ff};
			else if (coff == `CCP_OFF_MODE)
				nxt_rdata = {31'h0, mode_ff};
			else if (coff == `CCP_OFF_INSP_LOCK)
				nxt_rdata = {31'h0, insp_lock_ff};
			else if (coff == `CCP_OFF_ERASE_PROG)
				nxt_rdata = {31'h0, !erase_busy_ff};
			else if (coff == `CCP_OFF_REFILL_LOCK)
				nxt_rdata = {31'h0, refill_lock_ff};
		end
		`CCP_SPACE_INFO:
		begin
			// locked inspection hides content in cache operation
			if (!lock_eff && sw_addr[12] == 1'b0)
			begin
				nxt_rdata[TAG_W-1:0] = tag_mem[{info_idx[7:0], info_way}];
				nxt_rdata[`CCP_BIT_VALID] = valid_ff[{info_idx[7:0], info_way}];
				nxt_rdata[`CCP_BIT_RECENT] = recent_ff[info_idx[7:0]];
			end
		end
		`CCP_SPACE_DATA:
		begin
			if (!lock_eff)
				nxt_rdata = sw_line[data_word*32 +: 32];
		end
		default:
			nxt_rdata = `CCP_RST_ZERO;
	endcase
end

always @(posedge mclk)
begin
	if (!rst_n)
		sw_rdata_ff <= `CCP_RST_ZERO;
	else if (sw_rd)
		sw_rdata_ff <= nxt_rdata;
	else
		sw_rdata_ff <= `CCP_RST_ZERO;
end

endmodule

/* File: dv/ccp_cache_chk_props.sv */
`timescale 1ns/1ps
module ccp_cache_chk (
	input wire mclk, // clock
	input wire rst_n, // reset
	input wire [1:0] sw_space, // space
	input wire [12:0] sw_addr, // address
	input wire [31:0] sw_wdata, // wdata
	input wire sw_wr, // write
	input wire sw_rd, // read
	input wire [31:0] sw_rdata_ff, // rdata
	input wire fetch_req, // request
	input wire fetch_done_ff, // done
	input wire fetch_hit_ff, // hit
	input wire [31:0] fetch_rdata_ff // word
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	reg lock_ff;
	// ====
	// sticky lock copy, cleared by reset only
	always @(posedge mclk)
	begin
		if (!rst_n)
			lock_ff <= 1'b0;
		else if (sw_wr && sw_space == 2'h0 && sw_addr == 13'h0518 && sw_wdata[0])
			lock_ff <= 1'b1;
	end
	property p_done; fetch_req |=> fetch_done_ff; endproperty
	a_done: assert property (p_done) else $error("no fetch answer");
	property p_idle; !fetch_req |=> !fetch_done_ff && !fetch_hit_ff; endproperty
	a_idle: assert property (p_idle) else $error("stray fetch answer");
	property p_hold; fetch_done_ff && !fetch_hit_ff |-> $stable(fetch_rdata_ff); endproperty
	a_hold: assert property (p_hold) else $error("word moved on miss");
	property p_pair; fetch_hit_ff |-> fetch_done_ff; endproperty
	a_pair: assert property (p_pair) else $error("hit without answer");
	property p_rdz; !sw_rd |=> sw_rdata_ff == 32'h00000000; endproperty
	a_rdz: assert property (p_rdz) else $error("read data not cleared");
	property p_wo; sw_rd && sw_space == 2'h0 && (sw_addr == 13'h0504 || sw_addr == 13'h0508)
		|=> sw_rdata_ff == 32'h00000000; endproperty
	a_wo: assert property (p_wo) else $error("write-only reads nonzero");
	property p_en; sw_rd && sw_space == 2'h0 && (sw_addr == 13'h0500 || sw_addr == 13'h050C)
		|=> sw_rdata_ff[31:1] == 31'h00000000; endproperty
	a_en: assert property (p_en) else $error("enable upper bits set");
	property p_lock; sw_rd && sw_space == 2'h0 && sw_addr == 13'h0518 && lock_ff |=> sw_rdata_ff[0]; endproperty
	a_lock: assert property (p_lock) else $error("lock released");
endmodule

/* File: dv/ccp_flash_model.sv */
`timescale 1ns/1ps
module ccp_flash_model (
	input wire mclk, // clock
	input wire rst_n, // reset
	input wire fetch_req, // request
	input wire [31:0] fetch_addr, // address
	input wire fetch_done_ff, // done
	input wire fetch_hit_ff, // hit
	input wire refill_ready, // taken
	output reg refill_valid, // offer
	output reg [31:0] refill_addr, // line address
	output reg [127:0] refill_data // line
);
	reg [31:0] a_ff;
	reg [2:0] age_ff;
	always @(posedge mclk)
	begin
		if (fetch_req)
			a_ff <= {fetch_addr[31:4], 4'h0};
		if (!rst_n)
		begin
			refill_valid <= 1'b0;
			refill_addr <= 32'h00000000;
			refill_data <= 128'h0;
		end
		else if (refill_valid)
		begin
			age_ff <= age_ff + 3'h1;
			// a locked or bypassed cache never takes it, so give up
			if (refill_ready || age_ff == 3'h4)
			begin
				refill_valid <= 1'b0;
				refill_addr <= ~refill_addr;
				refill_data <= ~refill_data;
			end
		end
		else if (fetch_done_ff && !fetch_hit_ff)
		begin
			refill_valid <= 1'b1;
			age_ff <= 3'h0;
			refill_addr <= a_ff;
			refill_data <= {a_ff + 32'h0000000C, a_ff + 32'h00000008, a_ff + 32'h00000004, a_ff};
		end
	end
endmodule

/* File: dv/cache_control_and_profiling_tb_top.sv */
`timescale 1ns/1ps
`include "ccp_cache_map.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module cache_control_and_profiling_tb_top;
	logic mclk = 0, rst_n = 0, sw_wr = 0, sw_rd = 0, fetch_req = 0, fetch_instr = 0, fetch_region = 0;
	logic [1:0] sw_space = 0;
	logic [12:0] sw_addr = 0;
	logic [31:0] sw_wdata = 0, fetch_addr = 0, v;
	wire [31:0] sw_rdata_ff, fetch_rdata_ff, refill_addr;
	wire [127:0] refill_data;
	wire fetch_done_ff, fetch_hit_ff, refill_valid, refill_ready;
	int n_fail = 0, checked = 0, i;
	ccp_cache_ctrl uut (.mclk(mclk), .rst_n(rst_n), .sw_space(sw_space), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_ff(sw_rdata_ff), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_instr(fetch_instr), .fetch_region(fetch_region),
		.fetch_done_ff(fetch_done_ff), .fetch_hit_ff(fetch_hit_ff), .fetch_rdata_ff(fetch_rdata_ff),
		.refill_valid(refill_valid), .refill_addr(refill_addr), .refill_data(refill_data),
		.refill_ready(refill_ready));
	ccp_flash_model u_flash (.mclk(mclk), .rst_n(rst_n), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_done_ff(fetch_done_ff), .fetch_hit_ff(fetch_hit_ff), .refill_ready(refill_ready),
		.refill_valid(refill_valid), .refill_addr(refill_addr), .refill_data(refill_data));
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	// ====
	// bus and fetch tasks
	task wr(input [1:0] s, input [12:0] a, input [31:0] d);
		@(posedge mclk);
		{sw_space, sw_addr, sw_wdata, sw_wr} <= {s, a, d, 1'b1};
		@(posedge mclk);
		sw_wr <= 1'b0;
	endtask
	task rd(input [1:0] s, input [12:0] a);
		@(posedge mclk);
		{sw_space, sw_addr, sw_rd} <= {s, a, 1'b1};
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1;
		v = sw_rdata_ff;
	endtask
	task cr(input [1:0] s, input [12:0] a, input [31:0] e);
		rd(s, a);
		`CHK($sformatf("space %0d addr %h", s, a), e, v)
	endtask
	task fc(input [31:0] a, input ins, input rg, input eh);
		@(posedge mclk);
		{fetch_addr, fetch_instr, fetch_region, fetch_req} <= {a, ins, rg, 1'b1};
		@(posedge mclk);
		fetch_req <= 1'b0;
		#1;
		`CHK("fetch done", 1'b1, fetch_done_ff)
		`CHK("fetch hit", eh, fetch_hit_ff)
		if (eh)
			`CHK("fetch word", a & 32'hFFFFFFFC, fetch_rdata_ff)
		repeat (10) @(posedge mclk);
	endtask
	task poll;
		for (i = 0; i < 300; i++)
		begin
			rd(2'h0, 13'h051C);
			if (v[0] === 1'b1)
				break;
		end
		`CHK("erase status", 1'b1, v[0])
	endtask
	task results;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ====
	// tests
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		cr(0, 13'h0500, 0);
		cr(0, 13'h050C, 0);
		for (i = 0; i < 4; i++)
			cr(0, 13'(13'h0400 + i * 4), 0);
		$display("reset test done");
		wr(0, 13'h0500, 1);
		wr(0, 13'h050C, 1);
		fc(32'h1230, 1, 0, 0);
		fc(32'h1234, 1, 0, 1);
		fc(32'h2340, 0, 1, 0);
		fc(32'h2348, 0, 1, 1);
		for (i = 0; i < 8; i++)
			cr(0, 13'(13'h0400 + i / 4 * 32 + i % 4 * 4), 8'hC3 >> i & 1);
		cr(1, 13'h0118, 32'h40000001);
		for (i = 0; i < 4; i++)
			cr(2, 13'(13'h0460 + i * 4), 32'h1230 + i * 4);
		$display("profiling test done");
		wr(0, 13'h050C, 0);
		fc(32'h1230, 1, 0, 1);
		cr(0, 13'h0400, 1);
		wr(0, 13'h0510, 1);
		cr(0, 13'h0400, 0);
		cr(0, 13'h042C, 0);
		wr(0, 13'h0520, 1);
		fc(32'h5230, 1, 0, 0);
		fc(32'h5230, 1, 0, 0);
		fc(32'h1230, 1, 0, 1);
		wr(0, 13'h0520, 0);
		wr(0, 13'h0504, 1);
		cr(0, 13'h0504, 0);
		fc(32'h1230, 1, 0, 0);
		wr(0, 13'h0500, 0);
		wr(0, 13'h0500, 1);
		fc(32'h1230, 1, 0, 0);
		$display("lock test done");
		wr(0, 13'h0508, 1);
		poll;
		cr(2, 13'h0460, 0);
		fc(32'h1230, 1, 0, 0);
		wr(0, 13'h0514, 1);
		poll;
		cr(2, 13'h0460, 0);
		wr(2, 13'h0464, 32'hA5A55A5A);
		cr(2, 13'h0464, 32'hA5A55A5A);
		fc(32'h1230, 1, 0, 0);
		wr(0, 13'h0514, 0);
		rd(1, 13'h0118);
		`CHK("valid bit", 1'b0, v[30])
		$display("mode test done");
		wr(0, 13'h0518, 1);
		wr(0, 13'h0518, 0);
		cr(0, 13'h0518, 1);
		cr(1, 13'h0118, 0);
		$display("debug lock test done");
		results;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		results;
	end
endmodule
bind ccp_cache_ctrl ccp_cache_chk u_chk (.mclk(mclk), .rst_n(rst_n), .sw_space(sw_space), .sw_addr(sw_addr),
	.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_ff(sw_rdata_ff), .fetch_req(fetch_req),
	.fetch_done_ff(fetch_done_ff), .fetch_hit_ff(fetch_hit_ff), .fetch_rdata_ff(fetch_rdata_ff));
